// ===== verilog/eal_pkg.sv
// Package: register map, field positions and reset values of the alarm latch
package eal_pkg;
    localparam int          ADR_W          = 14;
    localparam int          IDX_W          = 12;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_CFG        = 12'h00b;
    localparam logic [11:0] IDX_LATCHED    = 12'h011;
    localparam logic [11:0] IDX_SEC_HIST   = 12'h012;
    localparam logic [11:0] IDX_PERSIST    = 12'h013;
    localparam logic [11:0] IDX_MASKS      = 12'h014;
    localparam logic [11:0] IDX_GRP_MASK   = 12'h020;
    localparam logic [11:0] IDX_EVT_STAT   = 12'h021;
    localparam logic [11:0] IDX_EVT_CLR    = 12'h022;
    localparam logic [11:0] IDX_EVT_EN     = 12'h023;
    localparam logic [11:0] IDX_EXT_STAT   = 12'h164;
    // Global configuration fields
    localparam int          CFG_RISE_BIT   = 7;
    localparam int          CFG_FALL_BIT   = 6;
    localparam int          CFG_GIM_BIT    = 5;
    localparam int          CFG_SHEN_BIT   = 3;
    // Line alarm bit positions
    localparam int          ALM_LOS        = 7;
    localparam int          ALM_AIS        = 6;
    localparam int          ALM_OOF        = 5;
    localparam int          ALM_RAI        = 4;
    localparam int          ALM_CFA        = 3;
    localparam int          ALM_MULTIFRAME_LOSS       = 2;
    localparam int          ALM_SLIP       = 1;
    localparam int          ALM_SIGNALING_CHANGE       = 0;
    // Bits that ignore the falling edge selection
    localparam logic [7:0]  RISE_ONLY_MASK = 8'h09;
    // Extended status fields
    localparam int          EXT_TS16_ALARM_SIGNAL_BIT  = 6;
    localparam int          EXT_ECRC_BIT   = 5;
    localparam int          EXT_TS16_REMOTE_ALARM_BIT  = 4;
    // Event status fields
    localparam int          EVT_EXT_BIT    = 0;
    localparam int          EVT_SEC_BIT    = 1;
    localparam int          EVT_W          = 2;
    // Reset values
    localparam logic [7:0]  CFG_RST        = 8'h20;
    localparam logic [7:0]  MASKS_RST      = 8'hff;
    localparam logic [7:0]  GRP_MASK_RST   = 8'h01;
    localparam logic [1:0]  EVT_EN_RST     = 2'h0;
    // TS16 alarm figures
    localparam logic [2:0]  TS16_ZERO_MIN  = 3'h4;
    localparam logic [1:0]  TS16_AIS_RUN   = 2'h2;
    localparam logic [1:0]  TS16_RAI_RUN   = 2'h3;
    localparam int          TS16_RAI_POS   = 2;
    // Excessive CRC-4 window
    localparam int          CRC_WIN_DEF    = 1000;
    localparam int          CRC_THR_DEF    = 915;
endpackage

// ===== verilog/eal_alarm_latch.sv
// Alarm latch, one-second shadow and TS16/CRC-4 alarm detection of one channel
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns

// Function
// - The remote alarm latch bit 4 sets on the edge(s) chosen by the rise/fall selection.
// - Latch bits 3 and 0 follow only the rising edge selection.
// - Latch bits 2 and 1 follow both the rising and falling selections.
// - A latched bit interrupts only with its mask, the global and group masks all clear.
// - A latched bit clears on a written 0, or on the second pulse with shadow enabled.
// - All shadow bits stay 0 while shadow enable (config bit 3) is 0.
// - A one-second shadow bit shows that its alarm occurred in the last interval.
// - A persistent shadow bit shows an alarm active that did not rise last interval.
// - A mask bit at 1 stops its latched bit from raising the interrupt.
// - TS16 ALARM_INDICATION_SIGNAL sets after two multiframes of at most three zeros, clears on two of four or more or on alignment.
// - Excessive CRC reads 1 while 915 or more of the last 1000 checks failed.
// - TS16 remote alarm sets after three successive multiframes with bit 2 of frame 0 at 1.
// - The extended status register shows live TS16 ALARM_INDICATION_SIGNAL, excessive CRC and TS16 remote alarm.
// - The edge selection comes from config bits 7 (rise) and 6 (fall).
// - Latch clearing by the second pulse happens on its rising edge with shadow enabled.
module eal_alarm_latch #(
    parameter int CRC_WIN = eal_pkg::CRC_WIN_DEF,
    parameter int CRC_THR = eal_pkg::CRC_THR_DEF
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [eal_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic [7:0]               line_status_i,
    input  wire logic                     sec_pulse_i,
    input  wire logic                     ts16_valid_i,
    input  wire logic                     ts16_frame0_i,
    input  wire logic [7:0]               ts16_octet_i,
    input  wire logic                     mf_aligned_i,
    input  wire logic                     crc_valid_i,
    input  wire logic                     crc_err_i,
    output logic                          irq_o
);
    import eal_pkg::*;

    localparam int CNT_W = $clog2(CRC_WIN + 1);
    localparam int PTR_W = $clog2(CRC_WIN);

    function automatic logic [3:0] zeros_in(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            n = n + {3'h0, ~v[i]};
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    logic [IDX_W-1:0] idx;
    logic             req;
    logic             wr_acc;
    logic             ack_ff;
    logic [31:0]      dat_ff;
    logic [7:0]       cfg_ff;
    logic [7:0]       latched_ff;
    logic [7:0]       hist_ff;
    logic [7:0]       persist_ff;
    logic [7:0]       masks_ff;
    logic [7:0]       grp_mask_ff;
    logic [EVT_W-1:0] evt_stat_ff;
    logic [EVT_W-1:0] evt_en_ff;
    logic [7:0]       ext_stat;
    logic             ts16_alarm_signal_ff;
    logic             ecrc_ff;
    logic             ts16_remote_alarm_ff;

    assign idx    = wb_adr_i[ADR_W-1:2];
    assign req    = wb_cyc_i & wb_stb_i;
    // Write lands on the edge where the master sees ack
    assign wr_acc = req & wb_we_i & ack_ff & wb_sel_i[0];
    assign ext_stat = {1'b0, ts16_alarm_signal_ff, ecrc_ff, ts16_remote_alarm_ff, 4'h0};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_ff <= 32'h0000_0000;
        else if (req & ~ack_ff)
        begin
            unique case (idx)
                IDX_CFG:      dat_ff <= {24'h0, cfg_ff};
                IDX_LATCHED:  dat_ff <= {24'h0, latched_ff};
                IDX_SEC_HIST: dat_ff <= {24'h0, hist_ff};
                IDX_PERSIST:  dat_ff <= {24'h0, persist_ff};
                IDX_MASKS:    dat_ff <= {24'h0, masks_ff};
                IDX_GRP_MASK: dat_ff <= {24'h0, grp_mask_ff};
                IDX_EVT_STAT: dat_ff <= {30'h0, evt_stat_ff};
                IDX_EVT_EN:   dat_ff <= {30'h0, evt_en_ff};
                IDX_EXT_STAT: dat_ff <= {24'h0, ext_stat};
                default:      dat_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_ff      <= CFG_RST;
            masks_ff    <= MASKS_RST;
            grp_mask_ff <= GRP_MASK_RST;
            evt_en_ff   <= EVT_EN_RST;
        end
        else if (wr_acc)
        begin
            if (idx == IDX_CFG)
                cfg_ff <= wb_dat_i[7:0];
            if (idx == IDX_MASKS)
                masks_ff <= wb_dat_i[7:0];
            if (idx == IDX_GRP_MASK)
                grp_mask_ff <= wb_dat_i[7:0];
            if (idx == IDX_EVT_EN)
                evt_en_ff <= wb_dat_i[EVT_W-1:0];
        end
    end

    logic sel_rise;
    logic sel_fall;
    logic sh_en;
    assign sel_rise = cfg_ff[CFG_RISE_BIT];
    assign sel_fall = cfg_ff[CFG_FALL_BIT];
    assign sh_en    = cfg_ff[CFG_SHEN_BIT];

    // ----------------------------------------------------------------
    // One-second pulse: pin, so synchronise before edge detect
    // ----------------------------------------------------------------
    logic sec_s1_ff;
    logic sec_s2_ff;
    logic sec_s3_ff;
    logic tick;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sec_s1_ff <= 1'b0;
            sec_s2_ff <= 1'b0;
            sec_s3_ff <= 1'b0;
        end
        else
        begin
            sec_s1_ff <= sec_pulse_i;
            sec_s2_ff <= sec_s1_ff;
            sec_s3_ff <= sec_s2_ff;
        end
    end

    assign tick = sec_s2_ff & ~sec_s3_ff;

    // ----------------------------------------------------------------
    // Latched line alarms
    // ----------------------------------------------------------------
    logic [7:0] prev_ff;
    logic [7:0] rose;
    logic [7:0] fell;
    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic [7:0] nxt_latched;

    assign rose   = line_status_i & ~prev_ff;
    assign fell   = ~line_status_i & prev_ff;
    // CFA and signaling change are event pulses; their fall means nothing
    assign set_ev = ({8{sel_rise}} & rose)
                  | ({8{sel_fall}} & fell & ~RISE_ONLY_MASK);
    assign clr_ev = ({8{wr_acc && idx == IDX_LATCHED}} & ~wb_dat_i[7:0])
                  | {8{tick & sh_en}};
    // New events win over a clear in the same cycle
    assign nxt_latched = (latched_ff & ~clr_ev) | set_ev;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_ff    <= 8'h00;
            latched_ff <= 8'h00;
        end
        else
        begin
            prev_ff    <= line_status_i;
            latched_ff <= nxt_latched;
        end
    end

    // ----------------------------------------------------------------
    // One-second and persistent shadows
    // ----------------------------------------------------------------
    logic [7:0] occ_ff;
    logic [7:0] rose_acc_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !sh_en)
        begin
            occ_ff      <= 8'h00;
            rose_acc_ff <= 8'h00;
            hist_ff     <= 8'h00;
            persist_ff  <= 8'h00;
        end
        else if (tick)
        begin
            hist_ff     <= occ_ff | line_status_i;
            persist_ff  <= line_status_i & ~(rose_acc_ff | rose);
            occ_ff      <= line_status_i;
            rose_acc_ff <= 8'h00;
        end
        else
        begin
            occ_ff      <= occ_ff | line_status_i;
            rose_acc_ff <= rose_acc_ff | rose;
        end
    end

    // ----------------------------------------------------------------
    // TS16 ALARM_INDICATION_SIGNAL and TS16 remote alarm
    // ----------------------------------------------------------------
    logic       mf_start;
    logic [2:0] zcnt_ff;
    logic       mf_seen_ff;
    logic [1:0] low_run_ff;
    logic [1:0] high_run_ff;
    logic [1:0] rai_run_ff;
    logic       align_prev_ff;
    logic       mf_low;
    logic [3:0] zsum;
    logic [3:0] zf;

    assign mf_start = ts16_valid_i & ts16_frame0_i;
    assign mf_low   = zcnt_ff < TS16_ZERO_MIN;
    assign zf       = zeros_in(ts16_octet_i);
    assign zsum     = {1'b0, zcnt_ff} + zf;

    // Zero count saturates at four; only the three-or-fewer test matters
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            zcnt_ff <= 3'h0;
        else if (mf_start)
            zcnt_ff <= (zf > 4'h4) ? TS16_ZERO_MIN : zf[2:0];
        else if (ts16_valid_i)
            zcnt_ff <= (zsum > 4'h4) ? TS16_ZERO_MIN : zsum[2:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mf_seen_ff    <= 1'b0;
            low_run_ff    <= 2'h0;
            high_run_ff   <= 2'h0;
            ts16_alarm_signal_ff      <= 1'b0;
            align_prev_ff <= 1'b0;
        end
        else
        begin
            align_prev_ff <= mf_aligned_i;
            if (mf_start)
                mf_seen_ff <= 1'b1;
            if (mf_start && mf_seen_ff)
            begin
                low_run_ff  <= mf_low ? ((low_run_ff == TS16_AIS_RUN)
                               ? low_run_ff : low_run_ff + 2'h1) : 2'h0;
                high_run_ff <= !mf_low ? ((high_run_ff == TS16_AIS_RUN)
                               ? high_run_ff : high_run_ff + 2'h1) : 2'h0;
            end
            if (mf_aligned_i && !align_prev_ff)
                ts16_alarm_signal_ff <= 1'b0;
            else if (mf_start && mf_seen_ff && mf_low
                     && low_run_ff == TS16_AIS_RUN - 2'h1)
                ts16_alarm_signal_ff <= 1'b1;
            else if (mf_start && mf_seen_ff && !mf_low
                     && high_run_ff == TS16_AIS_RUN - 2'h1)
                ts16_alarm_signal_ff <= 1'b0;
        end
    end

    // Recovery on the first frame 0 with the bit back at 0
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rai_run_ff <= 2'h0;
            ts16_remote_alarm_ff   <= 1'b0;
        end
        else if (mf_start)
        begin
            if (ts16_octet_i[TS16_RAI_POS])
            begin
                if (rai_run_ff != TS16_RAI_RUN)
                    rai_run_ff <= rai_run_ff + 2'h1;
                if (rai_run_ff == TS16_RAI_RUN - 2'h1)
                    ts16_remote_alarm_ff <= 1'b1;
            end
            else
            begin
                rai_run_ff <= 2'h0;
                ts16_remote_alarm_ff   <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Excessive CRC-4 errors over a sliding window
    // ----------------------------------------------------------------
    logic [CRC_WIN-1:0] crc_hist_ff;
    logic [PTR_W-1:0]   crc_ptr_ff;
    logic [CNT_W-1:0]   crc_cnt_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            crc_hist_ff <= '0;
            crc_ptr_ff  <= '0;
            crc_cnt_ff  <= '0;
            ecrc_ff     <= 1'b0;
        end
        else
        begin
            if (crc_valid_i)
            begin
                crc_hist_ff[crc_ptr_ff] <= crc_err_i;
                crc_cnt_ff <= crc_cnt_ff + CNT_W'(crc_err_i)
                            - CNT_W'(crc_hist_ff[crc_ptr_ff]);
                crc_ptr_ff <= (crc_ptr_ff == PTR_W'(CRC_WIN - 1))
                            ? '0 : crc_ptr_ff + PTR_W'(1);
            end
            // One cycle behind the count
            ecrc_ff <= crc_cnt_ff >= CNT_W'(CRC_THR);
        end
    end

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    logic       line_irq;
    logic [2:0] ext_prev_ff;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic       irq_ff;

    assign line_irq = (|(latched_ff & ~masks_ff)) & ~cfg_ff[CFG_GIM_BIT]
                    & ~grp_mask_ff[0];
    assign evt_set  = {tick, ext_prev_ff != {ts16_alarm_signal_ff, ecrc_ff, ts16_remote_alarm_ff}};
    assign evt_clr  = (wr_acc && idx == IDX_EVT_CLR)
                    ? wb_dat_i[EVT_W-1:0] : '0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_prev_ff <= 3'h0;
            evt_stat_ff <= '0;
            irq_ff      <= 1'b0;
        end
        else
        begin
            ext_prev_ff <= {ts16_alarm_signal_ff, ecrc_ff, ts16_remote_alarm_ff};
            evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
            irq_ff      <= line_irq | (|(evt_stat_ff & evt_en_ff));
        end
    end

    assign irq_o = irq_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_rai_latch;
        @(posedge clk_i) disable iff (rst_i)
        (sel_rise && $rose(line_status_i[ALM_RAI])) |=> latched_ff[ALM_RAI];
    endproperty
    a_rai_latch: assert property (p_rai_latch)
        else $error("remote alarm rise not latched");

    property p_cfa_no_fall;
        @(posedge clk_i) disable iff (rst_i)
        (!sel_rise && !latched_ff[ALM_CFA] && !clr_ev[ALM_CFA])
        |=> !latched_ff[ALM_CFA];
    endproperty
    a_cfa_no_fall: assert property (p_cfa_no_fall)
        else $error("realign change latched without rise selection");

    property p_slip_fall;
        @(posedge clk_i) disable iff (rst_i)
        (sel_fall && $fell(line_status_i[ALM_SLIP])) |=> latched_ff[ALM_SLIP];
    endproperty
    a_slip_fall: assert property (p_slip_fall)
        else $error("slip fall not latched");

    property p_irq_gate;
        @(posedge clk_i) disable iff (rst_i)
        line_irq |=> irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("unmasked latched bit gave no interrupt");

    property p_irq_masked;
        @(posedge clk_i) disable iff (rst_i)
        (cfg_ff[CFG_GIM_BIT] && !(|(evt_stat_ff & evt_en_ff))) |=> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt with global mask set");

    property p_wr_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr_acc && idx == IDX_LATCHED && !wb_dat_i[ALM_SIGNALING_CHANGE]
         && !set_ev[ALM_SIGNALING_CHANGE]) |=> !latched_ff[ALM_SIGNALING_CHANGE];
    endproperty
    a_wr_clear: assert property (p_wr_clear)
        else $error("written zero did not clear latch");

    property p_shadow_off;
        @(posedge clk_i) disable iff (rst_i)
        !sh_en |=> (hist_ff == 8'h00 && persist_ff == 8'h00);
    endproperty
    a_shadow_off: assert property (p_shadow_off)
        else $error("shadow nonzero while disabled");

    property p_hist_capture;
        @(posedge clk_i) disable iff (rst_i)
        (tick && sh_en) |=> hist_ff == ($past(occ_ff) | $past(line_status_i));
    endproperty
    a_hist_capture: assert property (p_hist_capture)
        else $error("one-second history not captured");

    property p_ecrc;
        @(posedge clk_i) disable iff (rst_i)
        ##1 (ecrc_ff == ($past(crc_cnt_ff) >= CNT_W'(CRC_THR)));
    endproperty
    a_ecrc: assert property (p_ecrc)
        else $error("excessive CRC status wrong");

    property p_ts16_remote_alarm;
        @(posedge clk_i) disable iff (rst_i)
        $rose(ts16_remote_alarm_ff) |-> $past(rai_run_ff) == TS16_RAI_RUN - 2'h1;
    endproperty
    a_ts16_remote_alarm: assert property (p_ts16_remote_alarm)
        else $error("TS16 remote alarm set early");

    c_tick_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        tick && sh_en && |latched_ff);
    c_ts16_alarm_signal: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(ts16_alarm_signal_ff));
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o));
endmodule

// ===== sim/eal_alarm_latch_tb_top.sv
// Testbench: register, interrupt, shadow and TS16/CRC-4 alarm checks
`timescale 1ns/1ns
module eal_alarm_latch_tb_top;
    import eal_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [13:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [7:0]  line = 8'h00;
    logic        sec = 1'b0;
    logic        tv = 1'b0;
    logic        tf0 = 1'b0;
    logic [7:0]  toct = 8'h00;
    logic        mfa = 1'b0;
    logic        cv = 1'b0;
    logic        ce = 1'b0;
    logic        irq_o;
    int          num_errors = 0;
    int          samples_checked = 0;

    eal_alarm_latch #(.CRC_WIN(20), .CRC_THR(18)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_status_i(line),
        .sec_pulse_i(sec), .ts16_valid_i(tv), .ts16_frame0_i(tf0),
        .ts16_octet_i(toct), .mf_aligned_i(mfa), .crc_valid_i(cv),
        .crc_err_i(ce), .irq_o(irq_o));

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked,
                 num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] ex,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== ex)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // ------------------------------------------------------------------
    // Bus cycle: hold the request until ack is sampled high
    // ------------------------------------------------------------------
    task automatic wb(input logic w, input logic [11:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o[7:0];
        cyc <= 1'b0;
        if (n >= 50)
            chk("ack", 8'h01, 8'h00);
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [11:0] idx, input logic [7:0] ex,
                      input string nm);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk(nm, ex, q);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic irq_is(input logic ex);
        wt(3);
        chk("irq", {7'h0, ex}, {7'h0, irq_o});
    endtask

    // Pin is asynchronous, so hold it past the two-stage synchroniser
    task automatic tick();
        sec <= 1'b1;
        wt(3);
        sec <= 1'b0;
        wt(8);
    endtask

    // One multiframe: frame 0 octet, then fifteen further octets
    task automatic mf(input logic [7:0] f0, input logic [7:0] rest);
        for (int i = 0; i < 16; i++)
        begin
            tv <= 1'b1;
            tf0 <= (i == 0);
            toct <= (i == 0) ? f0 : rest;
            wt(1);
            tv <= 1'b0;
            wt(1);
        end
    endtask

    task automatic crc(input int n, input logic e);
        repeat (n)
        begin
            cv <= 1'b1;
            ce <= e;
            wt(1);
            cv <= 1'b0;
            wt(1);
        end
        wt(3);
    endtask

    initial
    begin
        wt(20000);
        num_errors++;
        finish_test();
    end

    initial
    begin
        wt(3);
        rst_i <= 1'b0;
        wt(1);
        rd(IDX_CFG, CFG_RST, "cfg");
        rd(IDX_MASKS, MASKS_RST, "masks");
        rd(IDX_LATCHED, 8'h00, "latched");
        rd(12'h050, 8'h00, "unmapped");
        $display("Test reset values done");
        wr(IDX_GRP_MASK, 8'h00);
        wr(IDX_MASKS, 8'h00);
        wr(IDX_CFG, 8'h80);
        line <= 8'h1f;
        wt(2);
        rd(IDX_LATCHED, 8'h1f, "latched rise");
        irq_is(1'b1);
        wr(IDX_MASKS, 8'h1f);
        irq_is(1'b0);
        wr(IDX_MASKS, 8'h00);
        wr(IDX_CFG, 8'ha0);
        irq_is(1'b0);
        wr(IDX_CFG, 8'h80);
        wr(IDX_GRP_MASK, 8'h01);
        irq_is(1'b0);
        wr(IDX_GRP_MASK, 8'h00);
        wr(IDX_LATCHED, 8'hef);
        rd(IDX_LATCHED, 8'h0f, "write zero");
        wr(IDX_LATCHED, 8'h00);
        irq_is(1'b0);
        wr(IDX_CFG, 8'h40);
        line <= 8'h00;
        wt(2);
        rd(IDX_LATCHED, 8'h16, "latched fall");
        rd(IDX_SEC_HIST, 8'h00, "hist off");
        $display("Test latch and mask done");
        wr(IDX_LATCHED, 8'h00);
        wr(IDX_CFG, 8'h88);
        line <= 8'h01;
        wt(2);
        rd(IDX_LATCHED, 8'h01, "latched sig");
        tick();
        rd(IDX_LATCHED, 8'h00, "tick clear");
        rd(IDX_SEC_HIST, 8'h01, "hist");
        rd(IDX_PERSIST, 8'h00, "persist new");
        tick();
        rd(IDX_SEC_HIST, 8'h01, "hist held");
        rd(IDX_PERSIST, 8'h01, "persist");
        wr(IDX_CFG, 8'h80);
        rd(IDX_PERSIST, 8'h00, "persist off");
        $display("Test shadow done");
        crc(2, 1'b0);
        crc(17, 1'b1);
        wr(IDX_EXT_STAT, 8'h00);
        rd(IDX_EXT_STAT, 8'h00, "ecrc below");
        crc(1, 1'b1);
        rd(IDX_EXT_STAT, 8'h20, "ecrc");
        repeat (5) mf(8'hff, 8'hff);
        mf(8'hff, 8'hff);
        rd(IDX_EXT_STAT, 8'h70, "ts16 alarms");
        // Frame 0 keeps the remote alarm bit, the rest is all zeros
        repeat (3) mf(8'h04, 8'h00);
        rd(IDX_EXT_STAT, 8'h30, "ts16 zeros");
        repeat (3) mf(8'hff, 8'hff);
        rd(IDX_EXT_STAT, 8'h70, "ts16 again");
        mfa <= 1'b1;
        wt(3);
        rd(IDX_EXT_STAT, 8'h30, "ts16 aligned");
        rd(IDX_EVT_STAT, 8'h03, "evt stat");
        wr(IDX_EVT_EN, 8'h02);
        irq_is(1'b1);
        wr(IDX_EVT_CLR, 8'h02);
        irq_is(1'b0);
        rd(IDX_EVT_STAT, 8'h01, "evt clr");
        $display("Test extended status done");
        finish_test();
    end
endmodule
